/* File: oled_instr_regs.svh */
// constants for the character display instruction decoder
// assumes a 50 MHz core clock and an instruction byte bus
`ifndef OLED_INSTR_REGS_SVH
`define OLED_INSTR_REGS_SVH

// clock rate and clear-display time
`define CLK_HZ             50000000
`define CLEAR_TIME_US      6200
`define CLEAR_CYCLES       ((`CLEAR_TIME_US * (`CLK_HZ / 1000000)))
// busy cycles for all other instructions
`define SHORT_CYCLES       4
// ram sizes
`define DISPLAY_RAM_DEPTH  128
`define GLYPH_RAM_DEPTH    64
// blank character written by clear
`define BLANK_CHAR         8'h20
// reset values
`define FUNC_RESET         6'h38
`define ENTRY_RESET        2'h2

`endif

/* File: oled_instr_pkg.sv */
// types for the character display instruction decoder
// assumes nothing beyond the standard language
`default_nettype none
package oled_instr_pkg;

	// host transfer into the decoder
	typedef struct packed {
		logic       strobe;
		logic       register_select;
		logic       read_not_write;
		logic [7:0] data;
	} host_req_t;

	// display settings held by the decoder
	typedef struct packed {
		logic       increment;
		logic       shift_enable;
		logic       display_on;
		logic       cursor_on;
		logic       blink_on;
		logic       graphic_mode;
		logic       power_on;
		logic       bus_width_select;
		logic       two_lines;
		logic       tall_font;
		logic       font_table_high;
		logic       font_table_low;
		logic [6:0] shift_offset;
	} settings_t;

	// instruction classes
	typedef enum logic [3:0] {
		op_none, op_clear, op_home, op_entry, op_display, op_shift,
		op_mode, op_function, op_glyph_addr, op_display_addr
	} opcode_t;

	// sequencer states
	typedef enum logic [1:0] {
		st_idle, st_short, st_clear
	} state_t;

endpackage
`default_nettype wire

/* File: oled_instr_classify.sv */
// instruction classifier: highest set bit picks the command
// assumes a byte sampled with register-select low and a write
`default_nettype none
module oled_instr_classify (
	// command byte
	input  wire logic                   [7:0] cmd,
	// decoded class
	output oled_instr_pkg::opcode_t           op
);
	// priority on the highest set bit
	assign op = cmd[7] ? oled_instr_pkg::op_display_addr :
		cmd[6] ? oled_instr_pkg::op_glyph_addr :
		cmd[5] ? oled_instr_pkg::op_function :
		// bit 4 codes with low bits 01 or 10 are unused, never a lower class
		cmd[4] ? (cmd[1:0] == 2'b11 ? oled_instr_pkg::op_mode :
			cmd[1:0] == 2'b00 ? oled_instr_pkg::op_shift :
			oled_instr_pkg::op_none) :
		cmd[3] ? oled_instr_pkg::op_display :
		cmd[2] ? oled_instr_pkg::op_entry :
		cmd[1] ? oled_instr_pkg::op_home :
		cmd[0] ? oled_instr_pkg::op_clear :
		oled_instr_pkg::op_none;
endmodule
`default_nettype wire

/* File: char_oled_instruction_decoder.sv */
// instruction and data decoder of a two-line character display
// assumes synchronous one-cycle host strobes on the clock
// assumes the host polls busy before all but status reads
// clear holds busy for its full time; only status is answered then
// How it works
// - clear fills display ram, zeroes counter
// - home zeroes counter, undoes shift
// - entry mode stores direction and shift
// - display control stores on, cursor, blink
// - shift moves cursor or display only
// - mode command stores graphic and power
// - function set stores width, lines, font, table
// - glyph address load selects glyph ram
// - display address load selects display ram
// - status read returns busy and counter
// - data write goes to selected ram
// - data read comes from selected ram
// - busy ignores all but status read
// - counter steps after each data access
// - graphic one is graphic, power one on
// - lines one is two, font one tall
`include "oled_instr_regs.svh"
`default_nettype none
module char_oled_instruction_decoder (
	// clock and reset
	input  wire logic                      clock,
	input  wire logic                      reset_n,
	// host transfer
	input  wire oled_instr_pkg::host_req_t req,
	// read data back to the host
	output logic                     [7:0] read_data,
	output logic                           read_valid,
	// state seen by the display side
	output logic                           busy_flag,
	output logic                     [6:0] address_counter,
	output oled_instr_pkg::settings_t      settings,
	output logic                           glyph_select
);
	// busy lengths in clock cycles
	localparam int CLR_CYC = `CLEAR_CYCLES;
	localparam logic [18:0] CLR_LAST = 19'(CLR_CYC - 1);
	localparam logic [18:0] SHORT_LAST = 19'(`SHORT_CYCLES - 1);
	// settings after reset: entry bits, display and mode off, function bits
	localparam logic [1:0] ENTRY_RST = `ENTRY_RESET;
	localparam logic [4:0] FUNC_RST  = 5'(`FUNC_RESET); // class bit dropped
	localparam oled_instr_pkg::settings_t SET_RST =
		{ENTRY_RST, 5'h00, FUNC_RST, 7'h00};

	// step the counter in the chosen direction, wrapping in the ram size
	function automatic logic [6:0] step_addr(input logic [6:0] a,
		input logic up, input logic glyph);
		logic [6:0] n;
		n = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
		step_addr = glyph ? {1'b0, n[5:0]} : n;
	endfunction

	logic [7:0] display_mem [0:`DISPLAY_RAM_DEPTH-1];
	logic [7:0] glyph_mem   [0:`GLYPH_RAM_DEPTH-1];

	oled_instr_pkg::state_t    state_ff, nxt_state;
	oled_instr_pkg::settings_t set_ff, nxt_set;
	oled_instr_pkg::opcode_t   op;
	logic [18:0] count_ff, nxt_count;
	logic [6:0]  addr_ff, nxt_addr;
	logic        glyph_ff, nxt_glyph;
	logic [7:0]  rdata_ff, nxt_rdata;
	logic        rvalid_ff, nxt_rvalid;

	// transfer classes
	wire idle      = (state_ff == oled_instr_pkg::st_idle);
	wire cmd_wr    = req.strobe && !req.register_select &&
		!req.read_not_write && idle;
	wire stat_rd   = req.strobe && !req.register_select &&
		req.read_not_write;
	wire data_wr   = req.strobe && req.register_select &&
		!req.read_not_write && idle;
	wire data_rd   = req.strobe && req.register_select &&
		req.read_not_write && idle;
	wire data_acc  = data_wr || data_rd;
	wire clr_last  = (count_ff == CLR_LAST);
	wire [6:0] ram_idx = glyph_ff ? {1'b0, addr_ff[5:0]} : addr_ff;
	wire [7:0] ram_q   = glyph_ff ? glyph_mem[addr_ff[5:0]]
		: display_mem[addr_ff];

	// entry and display control fields
	wire       entry_up     = req.data[1];
	wire       entry_shift  = req.data[0];
	wire       disp_on      = req.data[2];
	wire       disp_cursor  = req.data[1];
	wire       disp_blink   = req.data[0];

	// move, mode and function fields
	wire       move_display = req.data[3];
	wire       move_right   = req.data[2];
	wire       mode_graphic = req.data[3];
	wire       mode_power   = req.data[2];
	wire       func_width   = req.data[4];
	wire       func_lines   = req.data[3];
	wire       func_font    = req.data[2];
	wire [1:0] func_table   = req.data[1:0];

	// address loads
	wire [5:0] glyph_load   = req.data[5:0];
	wire [6:0] display_load = req.data[6:0];

	// stepped counter and offset for data access and move commands
	wire [6:0] addr_step   = step_addr(addr_ff, set_ff.increment,
		glyph_ff);
	wire [6:0] addr_move   = step_addr(addr_ff, move_right, glyph_ff);
	wire [6:0] offset_step = step_addr(set_ff.shift_offset,
		set_ff.increment, 1'b0);
	wire [6:0] offset_move = step_addr(set_ff.shift_offset, move_right,
		1'b0);

	// ram write enables for host data
	wire       disp_wr    = data_wr && !glyph_ff;
	wire       glyph_wr   = data_wr && glyph_ff;

	// clear sweep over display ram, end of a short busy
	wire       sweep_wr   = (state_ff == oled_instr_pkg::st_clear) &&
		(count_ff < 19'(`DISPLAY_RAM_DEPTH));
	wire       short_last = (count_ff == SHORT_LAST);

	oled_instr_classify u_classify (
		.cmd (req.data),
		.op  (op)
	);

	// command, data and busy sequencing
	always_comb begin
		nxt_state  = state_ff;
		nxt_set    = set_ff;
		nxt_count  = count_ff;
		nxt_addr   = addr_ff;
		nxt_glyph  = glyph_ff;
		case (state_ff)
		oled_instr_pkg::st_idle: begin
			if (cmd_wr) begin
				nxt_state = oled_instr_pkg::st_short;
				nxt_count = 19'h0_0000;
				case (op)
				oled_instr_pkg::op_clear: begin
					nxt_state = oled_instr_pkg::st_clear;
					nxt_addr  = 7'h00;
					nxt_glyph = 1'b0;
					nxt_set.shift_offset = 7'h00;
				end
				oled_instr_pkg::op_home: begin
					// bit 0 is a test input, host keeps it low
					nxt_addr  = 7'h00;
					nxt_glyph = 1'b0;
					nxt_set.shift_offset = 7'h00;
				end
				oled_instr_pkg::op_entry: begin
					nxt_set.increment    = entry_up;
					nxt_set.shift_enable = entry_shift;
				end
				oled_instr_pkg::op_display: begin
					nxt_set.display_on = disp_on;
					nxt_set.cursor_on  = disp_cursor;
					nxt_set.blink_on   = disp_blink;
				end
				oled_instr_pkg::op_shift: begin
					if (move_display)
						nxt_set.shift_offset = offset_move;
					else
						nxt_addr = addr_move;
				end
				oled_instr_pkg::op_mode: begin
					nxt_set.graphic_mode = mode_graphic;
					nxt_set.power_on     = mode_power;
				end
				oled_instr_pkg::op_function: begin
					nxt_set.bus_width_select = func_width;
					nxt_set.two_lines        = func_lines;
					nxt_set.tall_font        = func_font;
					nxt_set.font_table_high  = func_table[1];
					nxt_set.font_table_low   = func_table[0];
				end
				oled_instr_pkg::op_glyph_addr: begin
					nxt_addr  = {1'b0, glyph_load};
					nxt_glyph = 1'b1;
				end
				oled_instr_pkg::op_display_addr: begin
					nxt_addr  = display_load;
					nxt_glyph = 1'b0;
				end
				default: nxt_state = oled_instr_pkg::st_idle;
				endcase
			end else if (data_acc) begin
				nxt_state = oled_instr_pkg::st_short;
				nxt_count = 19'h0_0000;
				nxt_addr  = addr_step;
				if (set_ff.shift_enable && !glyph_ff)
					nxt_set.shift_offset = offset_step;
			end
		end
		oled_instr_pkg::st_short: begin
			nxt_count = 19'(count_ff + 19'h0_0001);
			if (short_last)
				nxt_state = oled_instr_pkg::st_idle;
		end
		oled_instr_pkg::st_clear: begin
			nxt_count = 19'(count_ff + 19'h0_0001);
			if (clr_last)
				nxt_state = oled_instr_pkg::st_idle;
		end
		default: nxt_state = oled_instr_pkg::st_idle;
		endcase
	end

	// read answer: status any time, ram byte on an accepted data read
	always_comb begin
		nxt_rdata  = rdata_ff;
		nxt_rvalid = 1'b0;
		if (stat_rd) begin
			nxt_rdata  = {!idle, addr_ff};
			nxt_rvalid = 1'b1;
		end else if (data_rd) begin
			nxt_rdata  = ram_q;
			nxt_rvalid = 1'b1;
		end
	end

	// sequencer state
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			state_ff <= oled_instr_pkg::st_idle;
		else
			state_ff <= nxt_state;
	end

	// busy timer
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			count_ff <= 19'h0_0000;
		else
			count_ff <= nxt_count;
	end

	// display settings
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			set_ff <= SET_RST;
		else
			set_ff <= nxt_set;
	end

	// address counter
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			addr_ff <= 7'h00;
		else
			addr_ff <= nxt_addr;
	end

	// ram select, display ram after reset
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			glyph_ff <= 1'b0;
		else
			glyph_ff <= nxt_glyph;
	end

	// read data, held until the next read
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= nxt_rdata;
	end

	// read valid pulse
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			rvalid_ff <= 1'b0;
		else
			rvalid_ff <= nxt_rvalid;
	end

	// display ram: host writes, clear sweeps blanks one word a cycle
	always_ff @(posedge clock) begin
		if (disp_wr)
			display_mem[ram_idx] <= req.data;
		else if (sweep_wr)
			display_mem[count_ff[6:0]] <= `BLANK_CHAR;
	end

	// glyph ram writes
	always_ff @(posedge clock) begin
		if (glyph_wr)
			glyph_mem[ram_idx[5:0]] <= req.data;
	end

	// outputs
	assign read_data       = rdata_ff;
	assign read_valid      = rvalid_ff;
	assign busy_flag       = !idle;
	assign address_counter = addr_ff;
	assign settings        = set_ff;
	assign glyph_select    = glyph_ff;
endmodule
`default_nettype wire

/* File: host_model.sv */
// host processor model issuing one-cycle transfers
// assumes the decoder clock and its busy flag
`default_nettype none
module host_model (
	// clock and decoder state
	input  wire logic                      clock,
	input  wire logic                      busy_flag,
	// transfer to the decoder
	output var  oled_instr_pkg::host_req_t req
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req = '0;
	// wait up to 20 cycles for idle unless told not to, strobe, release the bus
	task automatic put(input logic rs, rw, input logic [7:0] d,
		input logic w);
		for (int n = 0; w && n < 20 && busy_flag !== 1'b0; n++) begin
			@(posedge clock);
			#1;
		end
		@(posedge clock);
		#1 req = '{1'b1, rs, rw, d};
		@(posedge clock);
		#1 req = '{1'b0, 1'b0, 1'b0, ~d};
	endtask
endmodule
`default_nettype wire

/* File: oled_monitor.sv */
// port assertions for the instruction decoder
// assumes a bind onto the decoder top module
`default_nettype none
module oled_monitor (
	input wire logic                      clock,
	input wire logic                      reset_n,
	input wire oled_instr_pkg::host_req_t req,
	input wire logic                [7:0] read_data,
	input wire logic                      read_valid,
	input wire logic                      busy_flag,
	input wire logic                [6:0] address_counter,
	input wire oled_instr_pkg::settings_t settings,
	input wire logic                      glyph_select
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	// accepted transfers and next counter value
	wire       go = req.strobe && !busy_flag;
	wire       cw = go && !req.register_select && !req.read_not_write;
	wire       dw = go && req.register_select;
	wire [7:0] d  = req.data;
	wire [6:0] nx = (settings.increment ? address_counter + 7'h01
		: address_counter - 7'h01) & (glyph_select ? 7'h3f : 7'h7f);
	sequence s_busy;
		busy_flag [*4] ##1 !busy_flag;
	endsequence
	property p_clr;
		cw && d == 8'h01 |=> busy_flag && !address_counter;
	endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_dsp;
		cw && d[7:3] == 5'h01 |=> {settings.display_on,
			settings.cursor_on, settings.blink_on} == $past(d[2:0]);
	endproperty
	a_dsp: assert property (p_dsp) else $error("display");
	property p_fun;
		cw && d[7:5] == 3'h1 |=> {settings.bus_width_select,
			settings.two_lines, settings.tall_font, settings.font_table_high,
			settings.font_table_low} == $past(d[4:0]);
	endproperty
	a_fun: assert property (p_fun) else $error("function");
	property p_cga;
		cw && d[7:6] == 2'h1 |=> glyph_select
			&& address_counter == $past(d[5:0]);
	endproperty
	a_cga: assert property (p_cga) else $error("glyph addr");
	property p_dda;
		cw && d[7] |=> !glyph_select && address_counter == $past(d[6:0]);
	endproperty
	a_dda: assert property (p_dda) else $error("display addr");
	property p_sta;
		req.strobe && !req.register_select && req.read_not_write |=>
			read_valid && read_data == {$past(busy_flag),
			$past(address_counter)};
	endproperty
	a_sta: assert property (p_sta) else $error("status");
	property p_stp;
		dw |=> address_counter == $past(nx);
	endproperty
	a_stp: assert property (p_stp) else $error("step");
	property p_bsy;
		dw |=> s_busy;
	endproperty
	a_bsy: assert property (p_bsy) else $error("busy");
endmodule
bind char_oled_instruction_decoder oled_monitor u_oled_monitor (.clock,
	.reset_n, .req, .read_data, .read_valid, .busy_flag, .address_counter,
	.settings, .glyph_select);
`default_nettype wire

/* File: char_oled_instruction_decoder_tb_top.sv */
// self-checking bench for the instruction decoder
// assumes the host model drives every transfer
`default_nettype none
module char_oled_instruction_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                      clock;
	logic                      reset_n;
	oled_instr_pkg::host_req_t req;
	logic                [7:0] read_data;
	logic                      read_valid;
	logic                      busy_flag;
	logic                [6:0] address_counter;
	oled_instr_pkg::settings_t settings;
	logic                      glyph_select;
	int                        n_mismatch;
	int                        checked;
	// decoder and host
	char_oled_instruction_decoder u_char_oled_instruction_decoder (.clock,
		.reset_n, .req, .read_data, .read_valid, .busy_flag,
		.address_counter, .settings, .glyph_select);
	host_model u_host_model (.clock, .busy_flag, .req);
	// clock and watchdog
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		#100us;
		n_mismatch++;
		end_sim();
	end
	// compare and count
	task automatic chk(input string nm, input logic [18:0] e, s);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, s);
		end
	endtask
	// one transfer: {select, read}, byte, wait for idle first
	task automatic x(input logic [1:0] k, input logic [7:0] d,
		input logic w = 1'b1);
		u_host_model.put(k[1], k[0], d, w);
	endtask
	task automatic end_sim();
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// reset values
	task automatic t_rst();
		chk("settings", 19'h4_0c00, settings);
		chk("counter", 0, address_counter);
		chk("glyph", 0, glyph_select);
	endtask
	// configuration commands, then an unused shift code
	task automatic t_cfg();
		x(2'h0, 8'h27);
		x(2'h0, 8'h0d);
		x(2'h0, 8'h1b);
		x(2'h0, 8'h04);
		chk("settings", 19'h1_6380, settings);
		x(2'h0, 8'h11);
		chk("busy", 0, busy_flag);
	endtask
	// write, refused write, read back, status while busy
	task automatic t_dat();
		x(2'h0, 8'h85);
		chk("counter", 7'h05, address_counter);
		x(2'h0, 8'h06);
		x(2'h2, 8'ha5);
		x(2'h2, 8'h3c, 1'b0);
		chk("counter", 7'h06, address_counter);
		x(2'h0, 8'h85);
		x(2'h3, 8'h00);
		chk("read", 8'ha5, read_data);
		chk("valid", 1, read_valid);
		x(2'h0, 8'h04);
		x(2'h2, 8'h77);
		x(2'h1, 8'h00, 1'b0);
		chk("status", 8'h85, read_data);
	endtask
	// glyph ram address, counter wrap, read back
	task automatic t_cgr();
		x(2'h0, 8'h7f);
		chk("glyph", 1, glyph_select);
		x(2'h0, 8'h06);
		x(2'h2, 8'h1e);
		chk("counter", 7'h00, address_counter);
		x(2'h0, 8'h7f);
		x(2'h3, 8'h00);
		chk("read", 8'h1e, read_data);
	endtask
	// cursor move, display shift, return home
	task automatic t_hom();
		x(2'h0, 8'h8a);
		x(2'h0, 8'h14);
		chk("counter", 7'h0b, address_counter);
		x(2'h0, 8'h1c);
		chk("counter", 7'h0b, address_counter);
		chk("shift", 1, settings.shift_offset);
		x(2'h0, 8'h02);
		chk("counter", 7'h00, address_counter);
		chk("shift", 0, settings.shift_offset);
		x(2'h0, 8'h07);
		x(2'h2, 8'h41);
		chk("shift", 1, settings.shift_offset);
		chk("counter", 7'h01, address_counter);
	endtask
	// clear runs long: check it, then reset mid-run
	task automatic t_clr();
		x(2'h0, 8'h01);
		chk("busy", 1, busy_flag);
		chk("counter", 7'h00, address_counter);
		repeat (200) @(posedge clock);
		x(2'h1, 8'h00, 1'b0);
		chk("status", 8'h80, read_data);
		@(posedge clock);
		#1 reset_n = 1'b0;
		repeat (8) @(posedge clock);
		#1 reset_n = 1'b1;
		t_rst();
	endtask
	initial begin
		reset_n = 1'b0;
		repeat (8) @(posedge clock);
		#1 reset_n = 1'b1;
		t_rst();
		t_cfg();
		t_dat();
		t_cgr();
		t_hom();
		t_clr();
		end_sim();
	end
endmodule
`default_nettype wire
